// file: hdl/dtr_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtr_regs.svh"

module dtr_ctrl
  import dtr_pkg::*;
(
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          ce,
  // link to device
  dtr_link_if.ctrl           link,
  // user request
  input  wire logic          req_valid,
  input  wire dtr_user_cmd_t req_cmd,
  input  wire logic [13:0]   req_addr,
  input  wire logic [15:0]   req_wdata,
  input  wire logic          req_odt,
  input  wire logic [2:0]    additive_latency,
  input  wire logic          slow_grade,
  output var  logic          req_ready,
  // user status
  output var  logic          freq_change_ok,
  output var  logic [15:0]   rd_data,
  output var  logic          rd_valid
);

  // (RULE8) ns time rounded up to clock edges
  localparam logic [7:0] PRECHARGE_PERIOD_CYCLES = dtr_round_up(`DTR_TRP_PS, `DTR_TCK_PS);

  typedef struct packed {
    dtr_pwr_t      pstate;
    logic          exit_slow;
    logic [2:0]    wr_rec;
    logic [7:0]    rd_wait;
    logic [7:0]    cmd_wait;
    logic          cke;
    dtr_link_cmd_t cmd;
    logic [13:0]   addr;
    logic          odt;
    logic [2:0]    wphase;
    logic [15:0]   wdata;
    logic [15:0]   rdata;
    logic          rvalid;
    logic          freq_ok;
  } dtr_ctl_state_t;

  dtr_ctl_state_t st;
  dtr_ctl_state_t next_st;
  logic           can_go;
  logic [7:0]     slow_base;

  // a request is refused while cmd_wait still runs, and a read also while rd_wait still runs
  always_comb begin
    slow_base = slow_grade ? 8'(`DTR_SLOW_EXIT_SLOW) : 8'(`DTR_SLOW_EXIT_FAST);
    can_go    = (st.cmd_wait == 8'd0) && !(req_cmd == DTR_U_RD && st.rd_wait != 8'd0);
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.cmd    = DTR_L_NOP;
    next_st.rvalid = link.dq_d2c_oe;
    next_st.rdata  = link.dq_d2c;
    next_st.odt    = req_odt;
    if (st.rd_wait != 8'd0) begin
      next_st.rd_wait = st.rd_wait - 8'd1;
    end
    if (st.cmd_wait != 8'd0) begin
      next_st.cmd_wait = st.cmd_wait - 8'd1;
    end
    // write burst: one beat then a stretched postamble
    if (st.wphase != 3'd0) begin
      next_st.wphase = st.wphase - 3'd1;
    end

    if (req_valid && can_go) begin
      case (req_cmd)
        DTR_U_MRS: begin
          next_st.cmd       = DTR_L_MRS;
          next_st.addr      = req_addr;
          next_st.exit_slow = req_addr[`DTR_MR_EXIT_BIT];
          next_st.wr_rec    = req_addr[`DTR_MR_WR_MSB:`DTR_MR_WR_LSB];
        end
        DTR_U_ACT: begin
          next_st.cmd    = DTR_L_ACT;
          next_st.pstate = DTR_P_ACTIVE;
        end
        DTR_U_RD: next_st.cmd = DTR_L_RD;
        DTR_U_WR, DTR_U_WRA: begin
          next_st.cmd    = (req_cmd == DTR_U_WR) ? DTR_L_WR : DTR_L_WRA;
          next_st.wdata  = req_wdata;
          next_st.wphase = 3'(1 + `DTR_POSTAMBLE_XTRA);
          if (req_cmd == DTR_U_WRA) begin
            next_st.pstate = DTR_P_IDLE;
            // (RULE9) write recovery plus precharge
            next_st.cmd_wait = 8'({5'd0, st.wr_rec} + 8'd1) + PRECHARGE_PERIOD_CYCLES;
          end
        end
        DTR_U_PRE: begin
          next_st.cmd    = DTR_L_PRE;
          next_st.pstate = DTR_P_IDLE;
        end
        DTR_U_PDE, DTR_U_SRE: begin
          if (st.pstate == DTR_P_IDLE || st.pstate == DTR_P_ACTIVE) begin
            next_st.cke = 1'b0;
            next_st.cmd = (req_cmd == DTR_U_SRE) ? DTR_L_REF : DTR_L_NOP;
            if (req_cmd == DTR_U_SRE) begin
              next_st.pstate = DTR_P_SREF;
            end else if (st.pstate == DTR_P_ACTIVE) begin
              next_st.pstate = DTR_P_ACT_PD;
            end else begin
              next_st.pstate = DTR_P_PRE_PD;
            end
          end
        end
        DTR_U_PDX, DTR_U_SRX: begin
          if (!st.cke) begin
            next_st.cke = 1'b1;
            // (RULE10) next command two edges after exit
            next_st.cmd_wait = 8'(`DTR_EXIT_TO_CMD - 1);
            next_st.pstate   = (st.pstate == DTR_P_ACT_PD) ? DTR_P_ACTIVE : DTR_P_IDLE;
            if (st.pstate == DTR_P_ACT_PD) begin
              // (RULE3) read gap depends on exit select
              // (RULE1) exit timing from bit 12
              next_st.rd_wait = st.exit_slow ? (slow_base - {5'd0, additive_latency} - 8'd1)
                                             : 8'(`DTR_FAST_EXIT_RD - 1);
            end
          end
        end
        default: ;
      endcase
    end
    // (RULE6) clock change allowed in self refresh or precharge-down
    // (RULE7) precharge-down change also needs termination off
    next_st.freq_ok = (next_st.pstate == DTR_P_SREF) || (next_st.pstate == DTR_P_PRE_PD && !next_st.odt);
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st        <= '0;
      st.pstate <= DTR_P_IDLE;
      st.cke    <= 1'b1;
      st.cmd    <= DTR_L_NOP;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // registered outputs, except ready, which combines the registered counters with req_cmd
  assign req_ready      = can_go;
  assign freq_change_ok = st.freq_ok;
  assign rd_data        = st.rdata;
  assign rd_valid       = st.rvalid;
  assign link.cke       = st.cke;
  assign link.cmd       = st.cmd;
  assign link.addr      = st.addr;
  assign link.odt       = st.odt;
  // (RULE11) strobe held for a long postamble
  assign link.dqs_oe    = (st.wphase != 3'd0);
  assign link.dqs_t     = (st.wphase == 3'(1 + `DTR_POSTAMBLE_XTRA));
  assign link.dqs_c     = ~link.dqs_t;
  assign link.dq_c2d    = st.wdata;
  assign link.dq_c2d_oe = (st.wphase == 3'(1 + `DTR_POSTAMBLE_XTRA));

endmodule : dtr_ctrl

`default_nettype wire

// file: shared/dtr_regs.svh
`ifndef DTR_REGS_SVH
`define DTR_REGS_SVH

// mode register field positions
`define DTR_MR_EXIT_BIT     12
`define DTR_MR_DQS_BIT      10
`define DTR_MR_WR_MSB       11
`define DTR_MR_WR_LSB       9
`define DTR_MR_RESET        14'h0000

// clock period and analog times in picoseconds
`define DTR_TCK_PS          4000
`define DTR_TRP_PS          15000

// cycle counts counted in clock edges
`define DTR_FAST_EXIT_RD    2
`define DTR_SLOW_EXIT_FAST  8
`define DTR_SLOW_EXIT_SLOW  7
`define DTR_EXIT_TO_CMD     2
`define DTR_ODT_ON_DLY      2
`define DTR_RD_LAT          3
`define DTR_POSTAMBLE_XTRA  2

`endif

// file: shared/dtr_pkg.sv
package dtr_pkg;

  // commands carried on the link with clock enable high, except REF entering self refresh and NOP entering or holding power-down, both with it low
  typedef enum logic [2:0] {
    DTR_L_NOP, DTR_L_MRS, DTR_L_ACT, DTR_L_RD, DTR_L_WR, DTR_L_WRA, DTR_L_PRE, DTR_L_REF
  } dtr_link_cmd_t;

  // commands offered by the controller's user
  typedef enum logic [3:0] {
    DTR_U_NOP, DTR_U_MRS, DTR_U_ACT, DTR_U_RD, DTR_U_WR, DTR_U_WRA, DTR_U_PRE,
    DTR_U_PDE, DTR_U_PDX, DTR_U_SRE, DTR_U_SRX
  } dtr_user_cmd_t;

  // power states seen by both ends
  typedef enum logic [2:0] {
    DTR_P_IDLE, DTR_P_ACTIVE, DTR_P_ACT_PD, DTR_P_PRE_PD, DTR_P_SREF
  } dtr_pwr_t;

  // round a picosecond time up to whole clock edges
  function automatic logic [7:0] dtr_round_up(input int unsigned t_ps, input int unsigned tck_ps);
    int unsigned n;
    n = (t_ps + tck_ps - 1) / tck_ps;
    if (n == 0) begin
      n = 1;
    end
    return n[7:0];
  endfunction : dtr_round_up

endpackage : dtr_pkg

// file: shared/dtr_link_if.sv
`timescale 1ns/10ps
`default_nettype none

interface dtr_link_if;
  import dtr_pkg::*;
  logic          cke;
  dtr_link_cmd_t cmd;
  logic [13:0]   addr;
  logic          odt;
  logic [15:0]   dq_c2d;
  logic          dq_c2d_oe;
  logic          dqs_t;
  logic          dqs_c;
  logic          dqs_oe;
  logic [15:0]   dq_d2c;
  logic          dq_d2c_oe;

  modport ctrl (output cke, cmd, addr, odt, dq_c2d, dq_c2d_oe, dqs_t, dqs_c, dqs_oe,
                input dq_d2c, dq_d2c_oe);
  modport dev  (input cke, cmd, addr, odt, dq_c2d, dq_c2d_oe, dqs_t, dqs_c, dqs_oe,
                output dq_d2c, dq_d2c_oe);
endinterface : dtr_link_if

`default_nettype wire

// file: hdl/dtr_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "dtr_regs.svh"

// Overview of operation
// (RULE1) mode bit 12 picks active power-down exit
// (RULE2) zero means fast exit, one slow
// (RULE3) controller waits 2 or 8/7 minus latency
// (RULE4) termination on two edges after odt high
// (RULE5) termination off two and half edges later
// (RULE6) clock changes only in self refresh/precharge-down
// (RULE7) precharge-down clock change follows dedicated procedure
// (RULE8) ns times rounded up to clock counts
// (RULE9) auto-precharge write gap is wr plus precharge
// (RULE10) command allowed two edges after power-down exit
// (RULE11) long write postamble tolerated, only turnaround cost
// (RULE12) bit 10 zero selects differential strobe capture
// (RULE13) read float and drive align with data
module dtr_device
  import dtr_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // link to controller
  dtr_link_if.dev          link,
  // user side: read data source
  input  wire logic [15:0] rd_data,
  // user side: status
  output var  logic [15:0] wr_data,
  output var  logic        wr_valid,
  output var  logic        term_on,
  output var  logic        term_off_half,
  output var  logic        slow_exit_sel,
  output var  logic        diff_strobe,
  output var  dtr_pwr_t    pwr_state,
  output var  logic        early_cmd
);

  typedef struct packed {
    logic                  exit_slow;
    logic                  dqs_single;
    logic [2:0]            wr_rec;
    dtr_pwr_t              pstate;
    logic [1:0]            exit_cnt;
    logic [1:0]            odt_sh;
    logic                  term_on;
    logic                  term_half;
    logic [`DTR_RD_LAT-1:0] rd_pipe;
    logic [15:0]           dq_out;
    logic                  dq_oe;
    logic                  wr_pend;
    logic [15:0]           wdata;
    logic                  wvalid;
    logic                  early;
  } dtr_dev_state_t;

  dtr_dev_state_t st;
  dtr_dev_state_t next_st;
  logic           strobe_hit;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_st.wvalid = 1'b0;
    next_st.early  = 1'b0;

    // (RULE4) termination on reference
    next_st.odt_sh    = {st.odt_sh[0], link.odt};
    // (RULE5) extra half edge before off; term_on held through the half cycle
    next_st.term_half = st.term_on & ~st.odt_sh[1] & ~st.term_half;
    next_st.term_on   = st.odt_sh[1] | next_st.term_half;

    if (st.exit_cnt != 2'd0) begin
      next_st.exit_cnt = st.exit_cnt - 2'd1;
    end

    // power state tracking from clock enable and commands
    case (st.pstate)
      DTR_P_IDLE, DTR_P_ACTIVE: begin
        if (!link.cke) begin
          if (link.cmd == DTR_L_REF) begin
            next_st.pstate = DTR_P_SREF;
          end else if (st.pstate == DTR_P_ACTIVE) begin
            next_st.pstate = DTR_P_ACT_PD;
          end else begin
            next_st.pstate = DTR_P_PRE_PD;
          end
        end else begin
          // (RULE10) a command at Tm+1 flagged
          if (link.cmd != DTR_L_NOP && st.exit_cnt != 2'd0) begin
            next_st.early = 1'b1;
          end
          case (link.cmd)
            DTR_L_MRS: begin
              // (RULE1) exit select stored
              next_st.exit_slow  = link.addr[`DTR_MR_EXIT_BIT];
              // (RULE12) strobe mode stored
              next_st.dqs_single = link.addr[`DTR_MR_DQS_BIT];
              next_st.wr_rec     = link.addr[`DTR_MR_WR_MSB:`DTR_MR_WR_LSB];
            end
            DTR_L_ACT: next_st.pstate = DTR_P_ACTIVE;
            DTR_L_PRE: next_st.pstate = DTR_P_IDLE;
            DTR_L_WRA: begin
              next_st.pstate  = DTR_P_IDLE;
              next_st.wr_pend = 1'b1;
            end
            DTR_L_WR:  next_st.wr_pend = 1'b1;
            default: ;
          endcase
        end
      end
      DTR_P_ACT_PD, DTR_P_PRE_PD, DTR_P_SREF: begin
        if (link.cke) begin
          // (RULE10) exit registered here at Tm
          next_st.exit_cnt = 2'(`DTR_EXIT_TO_CMD - 1);
          next_st.pstate   = (st.pstate == DTR_P_ACT_PD) ? DTR_P_ACTIVE : DTR_P_IDLE;
        end
      end
      default: next_st.pstate = DTR_P_IDLE;
    endcase

    // read data path
    next_st.rd_pipe = {st.rd_pipe[`DTR_RD_LAT-2:0], (link.cke && link.cmd == DTR_L_RD)};
    // (RULE13) enable and data share one edge
    next_st.dq_oe   = st.rd_pipe[`DTR_RD_LAT-1];
    next_st.dq_out  = st.rd_pipe[`DTR_RD_LAT-1] ? rd_data : 16'h0000;

    // (RULE11) one beat per write; lingering strobe ignored
    // the strobe beat arrives in the same cycle as the write command itself
    if ((st.wr_pend || (link.cke && (link.cmd == DTR_L_WR || link.cmd == DTR_L_WRA))) && strobe_hit) begin
      next_st.wr_pend = 1'b0;
      next_st.wdata   = link.dq_c2d;
      next_st.wvalid  = 1'b1;
    end
  end

  // (RULE12) differential crosspoint or single-ended strobe
  always_comb begin
    if (st.dqs_single) begin
      strobe_hit = link.dqs_oe & link.dqs_t;
    end else begin
      strobe_hit = link.dqs_oe & link.dqs_t & ~link.dqs_c;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st        <= '0;
      st.pstate <= DTR_P_IDLE;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from state flops
  assign link.dq_d2c    = st.dq_out;
  assign link.dq_d2c_oe = st.dq_oe;
  assign wr_data        = st.wdata;
  assign wr_valid       = st.wvalid;
  assign term_on        = st.term_on;
  assign term_off_half  = st.term_half;
  // (RULE2) zero fast, one slow
  assign slow_exit_sel  = st.exit_slow;
  assign diff_strobe    = ~st.dqs_single;
  assign pwr_state      = st.pstate;
  assign early_cmd      = st.early;

endmodule : dtr_device

`default_nettype wire

// file: tb/dtr_link_checker.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// link checker
// ----------------------------------------
module dtr_link_checker
  import dtr_pkg::*;
(
  // clock and reset
  input wire logic          core_clk,
  input wire logic          nrst,
  // link signals
  input wire logic          cke,
  input wire dtr_link_cmd_t cmd,
  input wire logic [13:0]   addr,
  input wire logic          dq_c2d_oe,
  input wire logic          dqs_t,
  input wire logic          dqs_c,
  input wire logic          dqs_oe,
  input wire logic          dq_d2c_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  logic [2:0] wr_fld;
  logic [3:0] gap_cnt;

  // recovery field kept from the last mode set; gap is field+1 plus 4 precharge cycles
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_fld  <= 3'h0;
      gap_cnt <= 4'h0;
    end else begin
      if (cmd == DTR_L_MRS) begin
        wr_fld <= addr[11:9];
      end
      if (cmd == DTR_L_WRA) begin
        gap_cnt <= 4'(wr_fld) + 4'h5;
      end else if (gap_cnt != 4'h0) begin
        gap_cnt <= gap_cnt - 4'h1;
      end
    end
  end

  sequence s_wr_beat;
    dqs_oe && dqs_t && !dqs_c && dq_c2d_oe;
  endsequence
  sequence s_postamble;
    (dqs_oe && !dqs_t) [*2];
  endsequence

  a_write_strobe_pair: assert property (cmd inside {DTR_L_WR, DTR_L_WRA} |-> s_wr_beat ##1 s_postamble)
    else $error("write strobe shape wrong");
  a_write_release: assert property ($fell(dqs_oe) |-> $past(cmd, 3) inside {DTR_L_WR, DTR_L_WRA})
    else $error("strobe release misplaced");
  a_data_under_strobe: assert property (dq_c2d_oe |-> dqs_oe && dqs_t)
    else $error("write data without strobe");
  a_read_drive_start: assert property (cmd == DTR_L_RD |-> ##4 dq_d2c_oe)
    else $error("read data not driven");
  a_read_drive_float: assert property (dq_d2c_oe |-> $past(cmd, 4) == DTR_L_RD)
    else $error("read drive outside window");
  a_exit_cmd_gap: assert property ($rose(cke) |-> cmd == DTR_L_NOP ##1 cmd == DTR_L_NOP)
    else $error("command too soon after exit");
  a_powered_down_quiet: assert property (!cke && !$past(cke) |-> cmd == DTR_L_NOP)
    else $error("command while powered down");
  a_wra_gap_hold: assert property (gap_cnt != 4'h0 |-> cmd == DTR_L_NOP)
    else $error("activate too soon after wra");
endmodule : dtr_link_checker

`default_nettype wire

// file: tb/ddr2_cycle_timing_rules_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// testbench top
// ----------------------------------------
module ddr2_cycle_timing_rules_tb_top;
  import dtr_pkg::*;
  logic          core_clk, nrst, ce, req_valid, req_odt, slow_grade;
  dtr_user_cmd_t req_cmd;
  logic [13:0]   req_addr;
  logic [15:0]   req_wdata, dev_rd_data, ctl_rd_data, wr_data;
  logic [2:0]    additive_latency;
  logic          req_ready, freq_change_ok, rd_valid, wr_valid, term_on, term_off_half;
  logic          slow_exit_sel, diff_strobe, early_cmd;
  logic          early_seen = 1'b0;
  dtr_pwr_t      pwr_state;
  int            n_errors, cmp_count, cyc, n, k;

  dtr_link_if link ();
  dtr_ctrl i_dtr_ctrl (.core_clk(core_clk), .nrst(nrst), .ce(ce), .link(link), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata), .req_odt(req_odt),
    .additive_latency(additive_latency), .slow_grade(slow_grade), .req_ready(req_ready),
    .freq_change_ok(freq_change_ok), .rd_data(ctl_rd_data), .rd_valid(rd_valid));
  dtr_device i_dtr_device (.core_clk(core_clk), .nrst(nrst), .ce(ce), .link(link), .rd_data(dev_rd_data),
    .wr_data(wr_data), .wr_valid(wr_valid), .term_on(term_on), .term_off_half(term_off_half),
    .slow_exit_sel(slow_exit_sel), .diff_strobe(diff_strobe), .pwr_state(pwr_state), .early_cmd(early_cmd));
  dtr_link_checker i_dtr_link_checker (.core_clk(core_clk), .nrst(nrst), .cke(link.cke), .cmd(link.cmd),
    .addr(link.addr), .dq_c2d_oe(link.dq_c2d_oe), .dqs_t(link.dqs_t), .dqs_c(link.dqs_c),
    .dqs_oe(link.dqs_oe), .dq_d2c_oe(link.dq_d2c_oe));

  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (early_cmd !== 1'b0 && nrst === 1'b1) begin
      early_seen = 1'b1;
    end
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  // valid stays high so back-to-back calls never toggle it; idle() drops it
  task automatic issue(input dtr_user_cmd_t c, input logic [13:0] a, output int m);
    m = 0;
    req_cmd = c;
    req_addr = a;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && m < 40) begin
      @(negedge core_clk);
      m++;
    end
    @(negedge core_clk);
    m++;
  endtask : issue

  task automatic idle(input int w);
    req_valid = 1'b0;
    repeat (w) @(negedge core_clk);
  endtask : idle

  task automatic finish_test();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // odt edge count: wait until the level reaches the link, then count edges
  task automatic odt_step(input logic lvl);
    req_odt = lvl;
    k = 0;
    while (link.odt !== lvl && k < 20) begin
      @(negedge core_clk);
      k++;
    end
    repeat (2) @(negedge core_clk);
  endtask : odt_step

  initial begin
    {nrst, ce, req_valid, req_odt, req_cmd, req_addr, req_wdata} = '0;
    ce = 1'b1;
    dev_rd_data = 16'hc3a5;
    additive_latency = 3'h1;
    slow_grade = 1'b1;
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    chk(16'(req_ready), 16'h0001);
    chk(16'(pwr_state), 16'(DTR_P_IDLE));
    // fast exit, differential strobe, recovery field 1
    issue(DTR_U_MRS, 14'h0200, n);
    idle(3);
    chk(16'(slow_exit_sel), 16'h0000);
    chk(16'(diff_strobe), 16'h0001);
    req_wdata = 16'h5a3c;
    issue(DTR_U_WR, 14'h0000, n);
    idle(0);
    k = 0;
    while (wr_valid !== 1'b1 && k < 20) begin
      @(negedge core_clk);
      k++;
    end
    chk(wr_data, 16'h5a3c);
    issue(DTR_U_RD, 14'h0000, n);
    idle(0);
    k = 0;
    while (rd_valid !== 1'b1 && k < 20) begin
      @(negedge core_clk);
      k++;
    end
    chk(ctl_rd_data, 16'hc3a5);
    issue(DTR_U_ACT, 14'h0000, n);
    issue(DTR_U_PDE, 14'h0000, n);
    idle(3);
    chk(16'(pwr_state), 16'(DTR_P_ACT_PD));
    chk(16'(freq_change_ok), 16'h0000);
    issue(DTR_U_PDX, 14'h0000, n);
    issue(DTR_U_RD, 14'h0000, n);
    chk(16'(n), 16'h0002);
    idle(8);
    // slow exit, recovery field 2
    issue(DTR_U_MRS, 14'h1400, n);
    idle(3);
    chk(16'(slow_exit_sel), 16'h0001);
    chk(16'(diff_strobe), 16'h0000);
    issue(DTR_U_PDE, 14'h0000, n);
    idle(3);
    issue(DTR_U_PDX, 14'h0000, n);
    issue(DTR_U_RD, 14'h0000, n);
    chk(16'(n), 16'h0006);
    idle(8);
    issue(DTR_U_PRE, 14'h0000, n);
    issue(DTR_U_PDE, 14'h0000, n);
    idle(3);
    chk(16'(pwr_state), 16'(DTR_P_PRE_PD));
    chk(16'(freq_change_ok), 16'h0001);
    issue(DTR_U_PDX, 14'h0000, n);
    issue(DTR_U_SRE, 14'h0000, n);
    idle(3);
    chk(16'(pwr_state), 16'(DTR_P_SREF));
    chk(16'(freq_change_ok), 16'h0001);
    issue(DTR_U_SRX, 14'h0000, n);
    issue(DTR_U_MRS, 14'h0200, n);
    issue(DTR_U_ACT, 14'h0000, n);
    issue(DTR_U_WRA, 14'h0000, n);
    issue(DTR_U_ACT, 14'h0000, n);
    chk(16'(n), 16'h0007);
    idle(4);
    odt_step(1'b1);
    chk(16'(term_on), 16'h0000);
    @(negedge core_clk);
    chk(16'(term_on), 16'h0001);
    odt_step(1'b0);
    chk(16'(term_off_half), 16'h0000);
    @(negedge core_clk);
    chk(16'(term_off_half), 16'h0001);
    chk(16'(term_on), 16'h0001);
    @(negedge core_clk);
    chk(16'(term_on), 16'h0000);
    chk(16'(early_seen), 16'h0000);
    finish_test();
  end
endmodule : ddr2_cycle_timing_rules_tb_top

`default_nettype wire
